/* File: rtl/pdmc_pkg.sv */
// pdmc_pkg: register map, field positions, reset values and serial frame constants
package pdmc_pkg;

  // register offsets within the master page (low address byte)
  localparam logic [7:0] ADDR_CORE_MASK_ONE = 8'h20;
  localparam logic [7:0] ADDR_BUF_MASK_ONE = 8'h21;
  localparam logic [7:0] ADDR_CORE_MASK_TWO = 8'h23;
  localparam logic [7:0] ADDR_BUF_MASK_TWO = 8'h24;
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h26;
  localparam logic [7:0] ADDR_INPUT_COUPLING = 8'h4f;
  localparam logic [7:0] ADDR_SYSREF_CTRL = 8'h53;
  localparam logic [7:0] ADDR_SYSREF_MANUAL = 8'h54;
  localparam logic [7:0] ADDR_MASK_APPLY = 8'h55;

  // field positions
  localparam int CORE_A_LSB = 4;
  localparam int CORE_B_LSB = 0;
  localparam int BUF_B_LSB = 6;
  localparam int BUF_A_LSB = 4;
  localparam int BIT_WHOLE_SLEEP = 7;
  localparam int BIT_PIN_IGNORE = 6;
  localparam int BIT_MASK_CHOICE = 5;
  localparam int BIT_MASK_APPLY = 4;
  localparam int BIT_CM_RAISE_OFF = 0;
  localparam int BIT_SYSREF_HIGH_CM = 1;
  localparam int BIT_SYSREF_LEVEL = 0;
  localparam int BIT_SYSREF_MANUAL = 7;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic RESET_BIT = 1'b0;

  // buffer field code that powers both buffers of a channel down
  localparam logic [1:0] BUF_CODE_DOWN = 2'h3;

  // serial frame: 1 read flag, 15 address bits, 8 data bits
  localparam logic [4:0] CMD_LAST_BIT = 5'h0f;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
  localparam logic [6:0] PAGE_ZERO = 7'h00;

  // serial engine states
  typedef enum logic [2:0] {
    PDMC_IDLE = 3'b001,
    PDMC_CMD = 3'b010,
    PDMC_DATA = 3'b100
  } pdmc_spi_state_t;

endpackage

/* File: rtl/pdmc_spi_slave.sv */
// pdmc_spi_slave: serial register interface engine, sampled on the system clock
module pdmc_spi_slave
  import pdmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  output logic [14:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata
);

  logic sen_s1_reg, sen_s2_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic sdin_s1_reg, sdin_s2_reg;
  pdmc_spi_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [14:0] shift_reg;
  logic read_reg;
  logic load_reg;
  logic [7:0] out_reg;
  logic sdout_reg;
  logic we_reg;
  logic [7:0] wdata_reg;
  logic [14:0] addr_reg;

  // pins come from another domain; edges are taken only between second and third flop
  always_ff @(posedge clock) begin
    if (reset) begin
      sen_s1_reg <= 1'b1;
      sen_s2_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      sdin_s1_reg <= 1'b0;
      sdin_s2_reg <= 1'b0;
    end else begin
      sen_s1_reg <= sen_n;
      sen_s2_reg <= sen_s1_reg;
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      sdin_s1_reg <= sdin;
      sdin_s2_reg <= sdin_s1_reg;
    end
  end

  // edge decode on synchronised serial clock
  wire sclk_rise = sclk_s2_reg & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_d_reg;
  wire selected = ~sen_s2_reg;
  wire cmd_done = sclk_rise & (bit_cnt_reg == CMD_LAST_BIT);
  wire frame_done = sclk_rise & (bit_cnt_reg == FRAME_LAST_BIT);

  // frame sequencer; deselect aborts any partial frame, so a short frame writes nothing
  always_ff @(posedge clock) begin
    if (reset || !selected) begin
      state_reg <= PDMC_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 15'h0000;
      we_reg <= 1'b0;
      load_reg <= 1'b0;
    end else begin
      we_reg <= 1'b0;
      load_reg <= cmd_done & shift_reg[14];
      if (sclk_rise && !state_reg[0]) begin
        shift_reg <= {shift_reg[13:0], sdin_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      unique case (state_reg)
        PDMC_IDLE: begin
          // a finished frame parks the count on its last bit, so trailing bits cannot open a second frame
          if (sclk_rise && (bit_cnt_reg == 5'h00)) begin
            shift_reg <= {shift_reg[13:0], sdin_s2_reg};
            bit_cnt_reg <= 5'h01;
            state_reg <= PDMC_CMD;
          end
        end
        PDMC_CMD: begin
          if (cmd_done) begin
            state_reg <= PDMC_DATA;
          end
        end
        PDMC_DATA: begin
          if (frame_done) begin
            we_reg <= ~read_reg;
            state_reg <= PDMC_IDLE;
            bit_cnt_reg <= FRAME_LAST_BIT;
          end
        end
      endcase
    end
  end

  // command capture and write data
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_reg <= 15'h0000;
      read_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (selected && cmd_done) begin
      addr_reg <= {shift_reg[13:0], sdin_s2_reg};
      read_reg <= shift_reg[14];
    end else if (selected && frame_done) begin
      wdata_reg <= {shift_reg[6:0], sdin_s2_reg};
    end
  end

  // read data loads one clock after the address settles, shifts out on falling edges
  always_ff @(posedge clock) begin
    if (reset || !selected) begin
      out_reg <= 8'h00;
      sdout_reg <= 1'b0;
    end else if (load_reg) begin
      out_reg <= reg_rdata;
    end else if (sclk_fall && read_reg && state_reg == PDMC_DATA) begin
      sdout_reg <= out_reg[7];
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  assign sdout = sdout_reg;
  assign reg_addr = addr_reg;
  assign reg_wdata = wdata_reg;
  assign reg_we = we_reg;

endmodule

/* File: rtl/pdmc_top.sv */
// pdmc_top: power-down mask, global power-down, coupling and sysref control registers
module pdmc_top
  import pdmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  input wire logic sleep_pin,
  input wire logic sysref_pin,
  output logic [3:0] core_sleep_chan_a,
  output logic [3:0] core_sleep_chan_b,
  output logic [1:0] buffer_sleep_chan_a,
  output logic [1:0] buffer_sleep_chan_b,
  output logic whole_device_sleep,
  output logic input_cm_raise_off,
  output logic sysref_high_cm_enable,
  output logic sysref_internal
);

  logic [14:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic [7:0] reg_rdata;

  logic [7:0] core_mask_one_reg, core_mask_two_reg;
  logic [3:0] buf_mask_one_reg, buf_mask_two_reg;
  logic whole_sleep_reg, pin_ignore_reg, mask_choice_reg, mask_apply_reg;
  logic cm_raise_off_reg, sysref_high_cm_reg, sysref_level_reg, sysref_manual_reg;
  logic sleep_s1_reg, sleep_s2_reg, sysref_s1_reg, sysref_s2_reg;
  logic [3:0] core_a_out_reg, core_b_out_reg;
  logic [1:0] buf_a_out_reg, buf_b_out_reg;
  logic whole_out_reg, cm_out_reg, sysref_hc_out_reg, sysref_out_reg;

  // buffer field decode; the unusable codes 01 and 10 leave the buffers running
  function automatic logic buf_down(input logic [1:0] code);
    buf_down = (code == BUF_CODE_DOWN);
  endfunction

  // address decode; upper address bits must be zero to hit the master page
  function automatic logic hit(input logic [14:0] addr, input logic [7:0] offset);
    hit = (addr[14:8] == PAGE_ZERO) && (addr[7:0] == offset);
  endfunction

  pdmc_spi_slave u_spi (
    .clock(clock),
    .reset(reset),
    .sen_n(sen_n),
    .sclk(sclk),
    .sdin(sdin),
    .sdout(sdout),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_rdata(reg_rdata)
  );

  // external pins are asynchronous to clock
  always_ff @(posedge clock) begin
    if (reset) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      sysref_s1_reg <= 1'b0;
      sysref_s2_reg <= 1'b0;
    end else begin
      sleep_s1_reg <= sleep_pin;
      sleep_s2_reg <= sleep_s1_reg;
      sysref_s1_reg <= sysref_pin;
      sysref_s2_reg <= sysref_s1_reg;
    end
  end

  // write strobes per register
  wire we_core_one = reg_we & hit(reg_addr, ADDR_CORE_MASK_ONE);
  wire we_buf_one = reg_we & hit(reg_addr, ADDR_BUF_MASK_ONE);
  wire we_core_two = reg_we & hit(reg_addr, ADDR_CORE_MASK_TWO);
  wire we_buf_two = reg_we & hit(reg_addr, ADDR_BUF_MASK_TWO);
  wire we_global = reg_we & hit(reg_addr, ADDR_GLOBAL_CTRL);
  wire we_coupling = reg_we & hit(reg_addr, ADDR_INPUT_COUPLING);
  wire we_sysref = reg_we & hit(reg_addr, ADDR_SYSREF_CTRL);
  wire we_sysref_man = reg_we & hit(reg_addr, ADDR_SYSREF_MANUAL);
  wire we_apply = reg_we & hit(reg_addr, ADDR_MASK_APPLY);

  // global gated
  // the global bit only accepts a write once the pin ignore bit is already set
  wire whole_sleep_next = (we_global && pin_ignore_reg) ? reg_wdata[BIT_WHOLE_SLEEP] : whole_sleep_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      core_mask_one_reg <= RESET_BYTE;
      buf_mask_one_reg <= RESET_NIBBLE;
    end else begin
      if (we_core_one) begin
        core_mask_one_reg <= reg_wdata;
      end
      if (we_buf_one) begin
        buf_mask_one_reg <= reg_wdata[7:4];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core_mask_two_reg <= RESET_BYTE;
      buf_mask_two_reg <= RESET_NIBBLE;
    end else begin
      if (we_core_two) begin
        core_mask_two_reg <= reg_wdata;
      end
      if (we_buf_two) begin
        buf_mask_two_reg <= {reg_wdata[BUF_B_LSB+1:BUF_B_LSB], reg_wdata[BUF_A_LSB+1:BUF_A_LSB]};
      end
    end
  end

  // reserved dropped
  // only documented bits are stored, so reserved positions cannot hold anything but zero
  always_ff @(posedge clock) begin
    if (reset) begin
      whole_sleep_reg <= RESET_BIT;
      pin_ignore_reg <= RESET_BIT;
      mask_choice_reg <= RESET_BIT;
      mask_apply_reg <= RESET_BIT;
      cm_raise_off_reg <= RESET_BIT;
      sysref_high_cm_reg <= RESET_BIT;
      sysref_level_reg <= RESET_BIT;
      sysref_manual_reg <= RESET_BIT;
    end else begin
      whole_sleep_reg <= whole_sleep_next;
      if (we_global) begin
        pin_ignore_reg <= reg_wdata[BIT_PIN_IGNORE];
        mask_choice_reg <= reg_wdata[BIT_MASK_CHOICE];
      end
      if (we_apply) begin
        mask_apply_reg <= reg_wdata[BIT_MASK_APPLY];
      end
      if (we_coupling) begin
        cm_raise_off_reg <= reg_wdata[BIT_CM_RAISE_OFF];
      end
      if (we_sysref) begin
        sysref_high_cm_reg <= reg_wdata[BIT_SYSREF_HIGH_CM];
        sysref_level_reg <= reg_wdata[BIT_SYSREF_LEVEL];
      end
      if (we_sysref_man) begin
        sysref_manual_reg <= reg_wdata[BIT_SYSREF_MANUAL];
      end
    end
  end

  wire [7:0] sel_core = mask_choice_reg ? core_mask_two_reg : core_mask_one_reg;
  wire [3:0] sel_buf = mask_choice_reg ? buf_mask_two_reg : buf_mask_one_reg;

  wire [7:0] act_core = mask_apply_reg ? sel_core : 8'h00;
  wire [3:0] act_buf = mask_apply_reg ? sel_buf : 4'h0;

  wire buf_a_off = buf_down(act_buf[1:0]);
  wire buf_b_off = buf_down(act_buf[3:2]);

  wire whole_sleep = pin_ignore_reg ? whole_sleep_reg : sleep_s2_reg;

  // cores follow buffer
  // whole-device sleep also forces every block down so the outputs tell one story
  wire [3:0] core_a_next = act_core[CORE_A_LSB+3:CORE_A_LSB] | {4{buf_a_off}} | {4{whole_sleep}};
  wire [3:0] core_b_next = act_core[CORE_B_LSB+3:CORE_B_LSB] | {4{buf_b_off}} | {4{whole_sleep}};
  wire [1:0] buf_a_next = {2{buf_a_off | whole_sleep}};
  wire [1:0] buf_b_next = {2{buf_b_off | whole_sleep}};

  wire sysref_next = sysref_manual_reg ? sysref_level_reg : sysref_s2_reg;

  // output flops; one clock of latency after any register change, three after a pin change through its two-flop synchroniser
  always_ff @(posedge clock) begin
    if (reset) begin
      core_a_out_reg <= RESET_NIBBLE;
      core_b_out_reg <= RESET_NIBBLE;
      buf_a_out_reg <= 2'h0;
      buf_b_out_reg <= 2'h0;
      whole_out_reg <= RESET_BIT;
      cm_out_reg <= RESET_BIT;
      sysref_hc_out_reg <= RESET_BIT;
      sysref_out_reg <= RESET_BIT;
    end else begin
      core_a_out_reg <= core_a_next;
      core_b_out_reg <= core_b_next;
      buf_a_out_reg <= buf_a_next;
      buf_b_out_reg <= buf_b_next;
      whole_out_reg <= whole_sleep;
      cm_out_reg <= cm_raise_off_reg;
      sysref_hc_out_reg <= sysref_high_cm_reg;
      sysref_out_reg <= sysref_next;
    end
  end

  // reserved read zero
  // readback: unmapped addresses read zero
  assign reg_rdata =
    hit(reg_addr, ADDR_CORE_MASK_ONE) ? core_mask_one_reg :
    hit(reg_addr, ADDR_BUF_MASK_ONE) ? {buf_mask_one_reg, 4'h0} :
    hit(reg_addr, ADDR_CORE_MASK_TWO) ? core_mask_two_reg :
    hit(reg_addr, ADDR_BUF_MASK_TWO) ? {buf_mask_two_reg, 4'h0} :
    hit(reg_addr, ADDR_GLOBAL_CTRL) ? {whole_sleep_reg, pin_ignore_reg, mask_choice_reg, 5'h00} :
    hit(reg_addr, ADDR_INPUT_COUPLING) ? {7'h00, cm_raise_off_reg} :
    hit(reg_addr, ADDR_SYSREF_CTRL) ? {6'h00, sysref_high_cm_reg, sysref_level_reg} :
    hit(reg_addr, ADDR_SYSREF_MANUAL) ? {sysref_manual_reg, 7'h00} :
    hit(reg_addr, ADDR_MASK_APPLY) ? {3'h0, mask_apply_reg, 4'h0} :
    8'h00;

  assign core_sleep_chan_a = core_a_out_reg;
  assign core_sleep_chan_b = core_b_out_reg;
  assign buffer_sleep_chan_a = buf_a_out_reg;
  assign buffer_sleep_chan_b = buf_b_out_reg;
  assign whole_device_sleep = whole_out_reg;
  assign input_cm_raise_off = cm_out_reg;
  assign sysref_high_cm_enable = sysref_hc_out_reg;
  assign sysref_internal = sysref_out_reg;

endmodule

/* File: tb/pdmc_top_asserts.sv */
// pdmc_top_asserts: port-level checks for the power-down control block
module pdmc_top_asserts
  import pdmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sdout,
  input wire logic sleep_pin,
  input wire logic sysref_pin,
  input wire logic [3:0] core_sleep_chan_a,
  input wire logic [3:0] core_sleep_chan_b,
  input wire logic [1:0] buffer_sleep_chan_a,
  input wire logic [1:0] buffer_sleep_chan_b,
  input wire logic whole_device_sleep,
  input wire logic input_cm_raise_off,
  input wire logic sysref_high_cm_enable,
  input wire logic sysref_internal
);
  logic [3:0] quiet_reg;
  logic [15:0] outs;
  assign outs = {core_sleep_chan_a, core_sleep_chan_b, buffer_sleep_chan_a, buffer_sleep_chan_b,
                 whole_device_sleep, input_cm_raise_off, sysref_high_cm_enable, sysref_internal};
  // cycles with no frame and no pin movement; saturates so it never wraps back to zero
  always_ff @(posedge clock) begin
    if (reset || !sen_n || $changed(sleep_pin) || $changed(sysref_pin)) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_buf_a_pair: assert property (buffer_sleep_chan_a[1] == buffer_sleep_chan_a[0])
    else $error("channel a buffer bits differ");
  a_buf_b_pair: assert property (buffer_sleep_chan_b[1] == buffer_sleep_chan_b[0])
    else $error("channel b buffer bits differ");
  a_buf_a_cores: assert property (buffer_sleep_chan_a == 2'h3 |-> core_sleep_chan_a == 4'hf)
    else $error("channel a cores awake behind sleeping buffer");
  a_buf_b_cores: assert property (buffer_sleep_chan_b == 2'h3 |-> core_sleep_chan_b == 4'hf)
    else $error("channel b cores awake behind sleeping buffer");
  a_whole_all_down: assert property (whole_device_sleep |-> outs[15:4] == 12'hfff)
    else $error("whole sleep left a block awake");
  a_release_clear: assert property ($fell(reset) |-> outs == 16'h0000)
    else $error("outputs not clear after reset");
  a_outputs_quiet: assert property (quiet_reg == 4'hf |-> $stable(outs))
    else $error("outputs moved without a write or pin change");
  a_sdout_idle: assert property (sen_n [*4] |-> !sdout)
    else $error("read data driven outside a frame");
endmodule
bind pdmc_top pdmc_top_asserts chk_u (.clock(clock), .reset(reset), .sen_n(sen_n), .sclk(sclk), .sdin(sdin),
  .sdout(sdout), .sleep_pin(sleep_pin), .sysref_pin(sysref_pin), .core_sleep_chan_a(core_sleep_chan_a),
  .core_sleep_chan_b(core_sleep_chan_b), .buffer_sleep_chan_a(buffer_sleep_chan_a),
  .buffer_sleep_chan_b(buffer_sleep_chan_b), .whole_device_sleep(whole_device_sleep),
  .input_cm_raise_off(input_cm_raise_off), .sysref_high_cm_enable(sysref_high_cm_enable),
  .sysref_internal(sysref_internal));

/* File: tb/test_pdmc_top.sv */
// test_pdmc_top: self-checking bench with a register model of the power-down control block
module test_pdmc_top
  import pdmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, reset = 1, sen_n = 1, sclk = 0, sdin = 0, sleep_pin = 0, sysref_pin = 0;
  logic sdout, whole_device_sleep, input_cm_raise_off, sysref_high_cm_enable, sysref_internal;
  logic [3:0] core_sleep_chan_a, core_sleep_chan_b;
  logic [1:0] buffer_sleep_chan_a, buffer_sleep_chan_b;
  int failures = 0, total_checks = 0;
  logic [7:0] mdl [0:255] = '{default: 8'h00};
  logic [31:0] seed = 32'ha77b;
  logic [7:0] q;
  logic [15:0] steps [16] = '{16'h2680, 16'h2640, 16'h26c0, 16'h2640, 16'h200f, 16'h21f0, 16'h5510, 16'h23f0,
                              16'h24c0, 16'h2660, 16'h245f, 16'h4f01, 16'h5303, 16'h5480, 16'h53ff, 16'h5500};

  pdmc_top dut_u (.clock(clock), .reset(reset), .sen_n(sen_n), .sclk(sclk), .sdin(sdin), .sdout(sdout),
    .sleep_pin(sleep_pin), .sysref_pin(sysref_pin), .core_sleep_chan_a(core_sleep_chan_a),
    .core_sleep_chan_b(core_sleep_chan_b), .buffer_sleep_chan_a(buffer_sleep_chan_a),
    .buffer_sleep_chan_b(buffer_sleep_chan_b), .whole_device_sleep(whole_device_sleep),
    .input_cm_raise_off(input_cm_raise_off), .sysref_high_cm_enable(sysref_high_cm_enable),
    .sysref_internal(sysref_internal));

  // free-running 50 MHz clock
  always #10 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // writable bits per register; off-page and unmapped places take nothing
  function automatic logic [7:0] wmask(logic [14:0] a);
    if (a[14:8] != PAGE_ZERO) return 8'h00;
    case (a[7:0])
      8'h20, 8'h23: return 8'hff;
      8'h21, 8'h24: return 8'hf0;
      8'h26: return 8'he0;
      8'h4f: return 8'h01;
      8'h53: return 8'h03;
      8'h54: return 8'h80;
      8'h55: return 8'h10;
      default: return 8'h00;
    endcase
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one frame, msb first; sclk phases of five clocks keep clear of the three-clock minimum
  // bits past the 24th repeat the command with inverted data, so a second write would show
  task automatic frame(logic rd, logic [14:0] a, logic [7:0] d, int nb, output logic [7:0] rq);
    logic [47:0] w;
    w = {rd, a, d, rd, a, ~d};
    rq = 8'h00;
    sen_n = 0;
    tick(4);
    for (int i = 0; i < nb; i++) begin
      sdin = w[47-i];
      sclk = 0;
      tick(5);
      if (i >= 16 && i < 24) rq[23-i] = sdout;
      sclk = 1;
      tick(5);
    end
    sclk = 0;
    tick(5);
    sen_n = 1;
    sdin = 0;
    tick(8);
  endtask

  task automatic check_outs();
    logic [7:0] core, bsel;
    logic [1:0] ba, bb;
    logic [3:0] ca, cb;
    logic wh, sy;
    core = mdl[8'h55][4] ? (mdl[8'h26][5] ? mdl[8'h23] : mdl[8'h20]) : 8'h00;
    bsel = mdl[8'h55][4] ? (mdl[8'h26][5] ? mdl[8'h24] : mdl[8'h21]) : 8'h00;
    ba = {2{bsel[5:4] == BUF_CODE_DOWN}};
    bb = {2{bsel[7:6] == BUF_CODE_DOWN}};
    ca = core[7:4] | {4{ba[0]}};
    cb = core[3:0] | {4{bb[0]}};
    wh = mdl[8'h26][6] ? mdl[8'h26][7] : sleep_pin;
    if (wh) begin
      {ca, cb, ba, bb} = 12'hfff;
    end
    sy = mdl[8'h54][7] ? mdl[8'h53][0] : sysref_pin;
    chk("core", {ca, cb}, {core_sleep_chan_a, core_sleep_chan_b});
    chk("buffer", {4'h0, ba, bb}, {4'h0, buffer_sleep_chan_a, buffer_sleep_chan_b});
    chk("whole", {7'h00, wh}, {7'h00, whole_device_sleep});
    chk("misc", {5'h00, mdl[8'h4f][0], mdl[8'h53][1], sy},
        {5'h00, input_cm_raise_off, sysref_high_cm_enable, sysref_internal});
  endtask

  task automatic wr(logic [14:0] a, logic [7:0] d, int nb);
    logic [7:0] m;
    frame(1'b0, a, d, nb, q);
    m = wmask(a);
    // global bit taken only once the pin is already ignored
    if (a[7:0] == 8'h26 && !mdl[8'h26][6]) m[7] = 1'b0;
    if (nb >= 24) mdl[a[7:0]] = (mdl[a[7:0]] & ~m) | (d & m);
    check_outs();
  endtask

  task automatic rdchk(logic [14:0] a);
    frame(1'b1, a, 8'h00, 24, q);
    chk("read", (wmask(a) != 8'h00) ? mdl[a[7:0]] : 8'h00, q);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog sized well above the roughly 45k cycles the tests need
  initial begin
    repeat (70000) @(posedge clock);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    tick(20);
    reset = 0;
    tick(4);
    for (int a = 8'h20; a <= 8'h56; a++) rdchk(15'(a));
    $display("test reset_values done");
    wr(15'h0055, 8'h10, 20);
    wr(15'h0155, 8'h10, 24);
    rdchk(15'h0055);
    rdchk(15'h0155);
    wr(15'h004f, 8'h00, 48);
    rdchk(15'h004f);
    $display("test refused_frames done");
    sleep_pin = 1;
    foreach (steps[i]) begin
      wr({7'h00, steps[i][15:8]}, steps[i][7:0], 24);
      rdchk({7'h00, steps[i][15:8]});
    end
    $display("test directed done");
    for (int i = 0; i < 40; i++) begin
      logic [31:0] r;
      r = rnd();
      sleep_pin = r[16];
      sysref_pin = r[17];
      wr({7'h00, steps[r[3:0]][15:8]}, r[15:8], 24);
      rdchk({7'h00, steps[r[3:0]][15:8]});
    end
    $display("test random done");
    complete_run();
  end
endmodule
